//--- design/sph_port.sv
// Purpose: One channel of a start-stop serial port with modem handshake.
// Assumes: Modem inputs and receive line are asynchronous pins.
// Notes: Instantiate twice for the first and second serial channel.
//
// Functional notes
// - Request-to-send rises when a character starts and falls when sending has ended.
// - A character starts only while data-set-ready is high and clear-to-send is high, or as the one extra character after clear-to-send drops.
// - After clear-to-send drops, at most the current and one more character go out.
// - Losing data-set-ready during a transfer aborts it and raises alarm code 086.
// - Terminal-ready stays high for as long as this port is ready to operate.
// - Each character is a start bit, eight data bits 1 to 8, then stop bits.
// - Carrier-detect is ignored and plays no part in transfer control.
// - Two channels exist; with a touch panel the second one is reserved for it.
// - When clear-to-send returns the pending data is sent on.
// - A halt code stops output within ten characters and a resume code restarts it.
`timescale 1ns/1ps
`default_nettype none
module sph_port
    import sph_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT,
    parameter bit RESERVED_FOR_PANEL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // User side: readiness and touch panel fitted
    input wire logic port_enable,
    input wire logic panel_fitted,
    // User side: character to send
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // User side: received character and alarm
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [7:0] alarm_code,
    output logic alarm_active,
    input wire logic alarm_clear,
    // Line pins
    output logic transmit_line,
    input wire logic receive_line,
    output logic request_to_send_out,
    input wire logic clear_to_send_in,
    input wire logic data_set_ready_in,
    output logic terminal_ready_out,
    input wire logic carrier_detect_in
);
    // ==========================================================
    // Pin synchronisers
    logic [2:0] sy1_q, sy2_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sy1_q <= 3'h7;
            sy2_q <= 3'h7;
        end else begin
            sy1_q <= {receive_line, clear_to_send_in, data_set_ready_in};
            sy2_q <= sy1_q;
        end
    end
    logic rxl, cts, dsr, cd_unused;
    assign rxl = sy2_q[2];
    assign cts = sy2_q[1];
    assign dsr = sy2_q[0];
    assign cd_unused = carrier_detect_in;

    // Second channel is withheld from general use while a panel is fitted
    logic usable;
    assign usable = port_enable && !(RESERVED_FOR_PANEL && panel_fitted);

    // ==========================================================
    // Receiver and flow codes
    logic [7:0] rxd;
    logic rxv;
    sph_rx #(.BAUD_DIV(BAUD_DIV)) u_rx (
        .clock(clock),
        .resetn(resetn),
        .rx_line(rxl),
        .rx_data(rxd),
        .rx_valid(rxv)
    );

    // ==========================================================
    // Transmitter
    sph_bit_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic txl_q, txl_d;
    logic rts_q, rts_d;
    logic dtr_q, dtr_d;
    logic rdy_q, rdy_d;
    logic halt_q, halt_d;
    logic [1:0] cts_drain_q, cts_drain_d;
    logic [7:0] alc_q, alc_d;
    logic ala_q, ala_d;
    logic [7:0] rxo_q, rxo_d;
    logic rxv_q, rxv_d;
    logic active;
    logic may_start;
    logic may_drain;
    assign active = (st_q != SPH_IDLE);
    assign may_start = cts && dsr && !halt_q && usable && !ala_q;
    // One extra character may start after clear-to-send drops; this also keeps
    // a cable that loops clear-to-send back to request-to-send moving
    assign may_drain = !cts && dsr && !halt_q && usable && !ala_q
                       && (cts_drain_q < 2'(CTS_DRAIN_MAX - 1));

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        txl_d = txl_q;
        rts_d = rts_q;
        halt_d = halt_q;
        cts_drain_d = cts_drain_q;
        alc_d = alc_q;
        ala_d = ala_q;
        rxo_d = rxo_q;
        rxv_d = 1'b0;
        dtr_d = usable;
        rdy_d = 1'b0;
        // Halt takes effect before the next character: well inside ten
        if (rxv && rxd == CODE_HALT) begin
            halt_d = 1'b1;
        end else if (rxv && rxd == CODE_RESUME) begin
            halt_d = 1'b0;
        end else if (rxv) begin
            rxo_d = rxd;
            rxv_d = 1'b1;
        end
        if (cts) begin
            cts_drain_d = 2'h0;
        end
        if (alarm_clear) begin
            ala_d = 1'b0;
            alc_d = ALARM_NONE;
        end
        case (st_q)
            SPH_IDLE: begin
                txl_d = 1'b1;
                rts_d = 1'b0;
                // Words wait at the source until accepted, so nothing is lost
                rdy_d = (may_start || may_drain) && !rdy_q;
                if (rdy_q && tx_valid && may_start) begin
                    st_d = SPH_START;
                    sh_d = tx_data;
                    rts_d = 1'b1;
                    txl_d = 1'b0;
                    cnt_d = 32'(BAUD_DIV - 1);
                end else if (rdy_q && tx_valid && may_drain) begin
                    // One character past the current may still leave
                    st_d = SPH_START;
                    sh_d = tx_data;
                    rts_d = 1'b1;
                    txl_d = 1'b0;
                    cnt_d = 32'(BAUD_DIV - 1);
                    cts_drain_d = cts_drain_q + 2'h1;
                end
            end
            SPH_START: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else begin
                    st_d = SPH_DATA;
                    bit_d = 4'h0;
                    txl_d = sh_q[0];
                    cnt_d = 32'(BAUD_DIV - 1);
                end
            end
            SPH_DATA: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else begin
                    cnt_d = 32'(BAUD_DIV - 1);
                    bit_d = bit_q + 4'h1;
                    sh_d = {1'b1, sh_q[7:1]};
                    if (bit_q == 4'(DATA_BITS - 1)) begin
                        st_d = SPH_STOP;
                        bit_d = 4'h0;
                        txl_d = 1'b1;
                    end else begin
                        txl_d = sh_q[1];
                    end
                end
            end
            SPH_STOP: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else if (bit_q == 4'(STOP_BITS - 1)) begin
                    st_d = SPH_IDLE;
                    rts_d = 1'b0;
                end else begin
                    bit_d = bit_q + 4'h1;
                    cnt_d = 32'(BAUD_DIV - 1);
                end
            end
            default: st_d = SPH_IDLE;
        endcase
        // Losing the partner mid-transfer aborts at once, mid-frame if need be
        if (active && !dsr) begin
            st_d = SPH_IDLE;
            txl_d = 1'b1;
            rts_d = 1'b0;
            ala_d = 1'b1;
            alc_d = ALARM_DSR_LOST;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= SPH_IDLE;
            cnt_q <= 32'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h0;
            txl_q <= 1'b1;
            rts_q <= 1'b0;
            dtr_q <= 1'b0;
            rdy_q <= 1'b0;
            halt_q <= 1'b0;
            cts_drain_q <= 2'h0;
            alc_q <= ALARM_NONE;
            ala_q <= 1'b0;
            rxo_q <= 8'h0;
            rxv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            txl_q <= txl_d;
            rts_q <= rts_d;
            dtr_q <= dtr_d;
            rdy_q <= rdy_d;
            halt_q <= halt_d;
            cts_drain_q <= cts_drain_d;
            alc_q <= alc_d;
            ala_q <= ala_d;
            rxo_q <= rxo_d;
            rxv_q <= rxv_d;
        end
    end

    // ==========================================================
    // Outputs
    assign transmit_line = txl_q;
    assign request_to_send_out = rts_q;
    assign terminal_ready_out = dtr_q;
    assign tx_ready = rdy_q;
    assign rx_data = rxo_q;
    assign rx_valid = rxv_q;
    assign alarm_code = alc_q;
    assign alarm_active = ala_q;
endmodule
`default_nettype wire

//--- design/sph_pkg.sv
// Purpose: Shared constants for the handshaking serial port.
// Assumes: 125 MHz clock, 8N2 framing, LSB (bit 1) first.
// Notes: Baud divisor is a parameter of the top module.
package sph_pkg;
    // ==========================================================
    // Framing
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned STOP_BITS = 2;
    localparam int unsigned FRAME_BITS = 1 + DATA_BITS + STOP_BITS;
    // ==========================================================
    // Timing
    localparam int unsigned CLOCK_HZ = 125000000;
    localparam int unsigned BAUD_DEFAULT = 9600;
    localparam int unsigned BAUD_DIV_DEFAULT = CLOCK_HZ / BAUD_DEFAULT;
    // ==========================================================
    // Flow control codes and limits
    localparam logic [7:0] CODE_RESUME = 8'h11;
    localparam logic [7:0] CODE_HALT = 8'h13;
    localparam int unsigned CTS_DRAIN_MAX = 2;
    localparam int unsigned XOFF_DRAIN_MAX = 10;
    localparam logic [7:0] ALARM_DSR_LOST = 8'h56;
    localparam logic [7:0] ALARM_NONE = 8'h00;
    typedef enum logic [1:0] {SPH_IDLE, SPH_START, SPH_DATA, SPH_STOP} sph_bit_state_t;
endpackage

//--- design/sph_rx.sv
// Purpose: Start-stop receiver for one channel.
// Assumes: Input already synchronised; samples mid-bit.
// Notes: Framing errors drop the character silently.
`timescale 1ns/1ps
`default_nettype none
module sph_rx
    import sph_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Line
    input wire logic rx_line,
    // Received character
    output logic [7:0] rx_data,
    output logic rx_valid
);
    // ==========================================================
    // Receive sequencer
    sph_bit_state_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] out_q, out_d;
    logic vld_q, vld_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        out_d = out_q;
        vld_d = 1'b0;
        case (st_q)
            SPH_IDLE: begin
                if (!rx_line) begin
                    st_d = SPH_START;
                    cnt_d = 32'(BAUD_DIV / 2);
                end
            end
            SPH_START: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else if (rx_line) begin
                    st_d = SPH_IDLE;
                end else begin
                    st_d = SPH_DATA;
                    cnt_d = 32'(BAUD_DIV - 1);
                    bit_d = 4'h0;
                end
            end
            SPH_DATA: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else begin
                    // Bit 1 arrives first
                    sh_d = {rx_line, sh_q[7:1]};
                    cnt_d = 32'(BAUD_DIV - 1);
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'(DATA_BITS - 1)) begin
                        st_d = SPH_STOP;
                    end
                end
            end
            SPH_STOP: begin
                if (cnt_q != 32'h0) begin
                    cnt_d = cnt_q - 32'h1;
                end else begin
                    st_d = SPH_IDLE;
                    if (rx_line) begin
                        out_d = sh_q;
                        vld_d = 1'b1;
                    end
                end
            end
            default: st_d = SPH_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= SPH_IDLE;
            cnt_q <= 32'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h0;
            out_q <= 8'h0;
            vld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign rx_data = out_q;
    assign rx_valid = vld_q;
endmodule
`default_nettype wire

//--- sim/sph_port_properties.sv
// Purpose: Checker for one serial port channel, bound to sph_port.
// Assumes: Synchronous user inputs, 2FF-synced modem pins.
// Notes: Frame length counted on request-to-send.
`timescale 1ns/1ps
`default_nettype none
module sph_port_properties
    import sph_pkg::*;
#(
    parameter int unsigned BAUD_DIV = BAUD_DIV_DEFAULT,
    parameter bit RESERVED_FOR_PANEL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // User side
    input wire logic port_enable,
    input wire logic panel_fitted,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] alarm_code,
    input wire logic alarm_active,
    input wire logic alarm_clear,
    // Line pins
    input wire logic transmit_line,
    input wire logic request_to_send_out,
    input wire logic data_set_ready_in,
    input wire logic terminal_ready_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ======================================
    // Cycles spent with request-to-send high
    int unsigned hi_q;
    int unsigned hi_d;
    always_comb hi_d = request_to_send_out ? hi_q + 1 : 0;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            hi_q <= 0;
        else
            hi_q <= hi_d;
    end
    sequence s_start;
        $rose(request_to_send_out);
    endsequence
    sequence s_frame_end;
        $fell(request_to_send_out) && !alarm_active;
    endsequence
    AST_START_LOW: assert property (s_start |-> !transmit_line)
        else $error("start bit missing at rts rise");
    AST_IDLE_HIGH: assert property (!request_to_send_out |-> transmit_line)
        else $error("line low without rts");
    AST_START_GATE: assert property (s_start |-> terminal_ready_out && !alarm_active)
        else $error("char started while not allowed");
    AST_START_TAKEN: assert property (s_start |-> $past(tx_ready) && $past(tx_valid))
        else $error("char started without a taken request");
    AST_FRAME_LEN: assert property (s_frame_end |-> hi_q == FRAME_BITS * BAUD_DIV)
        else $error("frame length wrong");
    AST_DSR_ALARM: assert property ($fell(data_set_ready_in) && request_to_send_out && hi_q > 0
        && hi_q < 8 * BAUD_DIV |-> ##[1:4] (alarm_active && alarm_code == ALARM_DSR_LOST))
        else $error("no alarm after dsr loss");
    AST_ABORT_QUIET: assert property (alarm_active |=> !request_to_send_out && transmit_line)
        else $error("sending during alarm");
    AST_ALARM_STICKY: assert property (alarm_active && !alarm_clear |=> alarm_active)
        else $error("alarm dropped without clear");
    AST_READY_OFF: assert property (!port_enable |-> ##[1:2] !terminal_ready_out)
        else $error("terminal ready while disabled");
    AST_READY_ON: assert property (port_enable && !(RESERVED_FOR_PANEL && panel_fitted)
        |-> ##[1:2] terminal_ready_out)
        else $error("terminal ready missing");
endmodule
bind sph_port sph_port_properties #(.BAUD_DIV(BAUD_DIV), .RESERVED_FOR_PANEL(RESERVED_FOR_PANEL))
    u_sph_port_properties (.clock(clock), .resetn(resetn), .port_enable(port_enable),
    .panel_fitted(panel_fitted), .tx_valid(tx_valid), .tx_ready(tx_ready), .alarm_code(alarm_code),
    .alarm_active(alarm_active), .alarm_clear(alarm_clear), .transmit_line(transmit_line),
    .request_to_send_out(request_to_send_out), .data_set_ready_in(data_set_ready_in),
    .terminal_ready_out(terminal_ready_out));
`default_nettype wire

//--- sim/sph_far_model.sv
// Purpose: Far serial device: frame receiver and code sender.
// Assumes: Same bit period as the port, 8 data bits, 2 stop bits.
// Notes: Line from the port is trusted only while terminal-ready is high.
`timescale 1ns/1ps
`default_nettype none
module sph_far_model
    import sph_pkg::*;
#(
    parameter int unsigned BAUD_DIV = 4
) (
    // Clock
    input wire logic clock,
    // From the port
    input wire logic transmit_line,
    input wire logic terminal_ready_out,
    // To the port
    output logic receive_line
);
    logic [7:0] got[$];
    logic [7:0] sh;
    int bad_stops = 0;
    initial receive_line = 1'b1;
    // ======================================
    // Receiver, sampling mid-bit
    always begin
        @(negedge transmit_line);
        if (terminal_ready_out) begin
            repeat (BAUD_DIV / 2) @(posedge clock);
            for (int i = 0; i < DATA_BITS + STOP_BITS; i++) begin
                repeat (BAUD_DIV) @(posedge clock);
                if (i < DATA_BITS)
                    sh[i] = transmit_line;
                else if (!transmit_line)
                    bad_stops++;
            end
            got.push_back(sh);
        end
    end
    task automatic send_byte(input logic [7:0] b);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge clock);
            receive_line = f[i];
            repeat (BAUD_DIV - 1) @(negedge clock);
        end
    endtask
endmodule
`default_nettype wire

//--- sim/serial_port_handshake_tb.sv
// Purpose: Self-checking bench for one serial port channel.
// Assumes: Short bit period so frames are 44 cycles.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module serial_port_handshake_tb;
    import sph_pkg::*;
    localparam int unsigned DIV = 4;
    localparam int unsigned FRAME = FRAME_BITS * DIV;
    // Rows: carrier detect, panel fitted, char sent, char expected
    localparam logic [17:0] ROWS [4] = '{{2'b00, 8'h00, 8'h00}, {2'b11, 8'hff, 8'hff},
        {2'b10, 8'ha5, 8'ha5}, {2'b01, 8'h5a, 8'h5a}};
    logic clock = 1'b0, resetn = 1'b0, port_enable = 1'b1, panel_fitted = 1'b0, tx_valid = 1'b0;
    logic alarm_clear = 1'b0, clear_to_send_in = 1'b1, data_set_ready_in = 1'b1, carrier_detect_in = 1'b0;
    logic [7:0] tx_data = 8'h00, rx_data, alarm_code;
    logic tx_ready, rx_valid, alarm_active, transmit_line, receive_line, request_to_send_out;
    logic terminal_ready_out, ok;
    int fails = 0, checks_done = 0, n;
    always #4 clock = ~clock;
    sph_port #(.BAUD_DIV(DIV), .RESERVED_FOR_PANEL(1'b0)) u_sph_port (.clock(clock), .resetn(resetn),
        .port_enable(port_enable), .panel_fitted(panel_fitted), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .alarm_code(alarm_code),
        .alarm_active(alarm_active), .alarm_clear(alarm_clear), .transmit_line(transmit_line),
        .receive_line(receive_line), .request_to_send_out(request_to_send_out),
        .clear_to_send_in(clear_to_send_in), .data_set_ready_in(data_set_ready_in),
        .terminal_ready_out(terminal_ready_out), .carrier_detect_in(carrier_detect_in));
    sph_far_model #(.BAUD_DIV(DIV)) u_sph_far_model (.clock(clock), .transmit_line(transmit_line),
        .terminal_ready_out(terminal_ready_out), .receive_line(receive_line));
    // Second channel: withheld from general use while a touch panel is fitted
    logic p2_dtr;
    if (1) begin : g_panel_channel
        sph_port #(.BAUD_DIV(DIV), .RESERVED_FOR_PANEL(1'b1)) u_sph_port (.clock(clock), .resetn(resetn),
            .port_enable(port_enable), .panel_fitted(panel_fitted), .tx_data(tx_data), .tx_valid(tx_valid),
            .tx_ready(), .rx_data(), .rx_valid(), .alarm_code(), .alarm_active(), .alarm_clear(alarm_clear),
            .transmit_line(), .receive_line(receive_line), .request_to_send_out(),
            .clear_to_send_in(clear_to_send_in), .data_set_ready_in(data_set_ready_in),
            .terminal_ready_out(p2_dtr), .carrier_detect_in(carrier_detect_in));
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Request held until tx_ready is seen or lim cycles pass, taken at the next rising edge
    task automatic send_char(input logic [7:0] d, input int lim, output logic taken);
        int k;
        k = 0;
        @(negedge clock);
        tx_data = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && k < lim) begin
            @(negedge clock);
            k++;
        end
        taken = (tx_ready === 1'b1);
        @(negedge clock);
        tx_valid = 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge clock);
        check("reset line rts", {6'h00, transmit_line, request_to_send_out}, 8'h02);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        check("terminal ready", {7'h00, terminal_ready_out}, 8'h01);
        foreach (ROWS[i]) begin
            {carrier_detect_in, panel_fitted} = ROWS[i][17:16];
            send_char(ROWS[i][15:8], 3000, ok);
            repeat (FRAME + 8) @(negedge clock);
            check("echo", u_sph_far_model.got.pop_front(), ROWS[i][7:0]);
            check("panel channel ready", {7'h00, p2_dtr}, {7'h00, ~ROWS[i][16]});
        end
        // ======================================
        // Clear-to-send looped back to request-to-send
        fork
            begin
                send_char(8'h41, 3000, ok);
                send_char(8'h42, 3000, ok);
            end
            begin
                repeat (4 * FRAME) begin
                    @(negedge clock);
                    clear_to_send_in = request_to_send_out;
                end
                @(negedge clock);
                clear_to_send_in = 1'b1;
            end
        join
        check("looped cts first", u_sph_far_model.got.pop_front(), 8'h41);
        check("looped cts second", u_sph_far_model.got.pop_front(), 8'h42);
        // ======================================
        // Clear-to-send dropped during a stream
        fork
            for (int k = 0; k < 5; k++) send_char(8'h30 + 8'(k), 3000, ok);
            begin
                @(posedge request_to_send_out);
                @(negedge clock);
                clear_to_send_in = 1'b0;
                repeat (6 * FRAME) @(negedge clock);
                check("chars after cts drop", 8'(u_sph_far_model.got.size()), 8'h02);
                clear_to_send_in = 1'b1;
            end
        join
        repeat (2 * FRAME) @(negedge clock);
        for (int k = 0; k < 5; k++)
            check("resumed stream", u_sph_far_model.got.pop_front(), 8'h30 + 8'(k));
        check("bad stops", 8'(u_sph_far_model.bad_stops), 8'h00);
        // ======================================
        // Halt and resume codes, then plain receive
        u_sph_far_model.send_byte(CODE_HALT);
        repeat (2 * DIV) @(negedge clock);
        fork
            send_char(8'h77, 3000, ok);
            begin
                repeat (3 * FRAME) @(negedge clock);
                check("chars while halted", 8'(u_sph_far_model.got.size()), 8'h00);
                u_sph_far_model.send_byte(CODE_RESUME);
            end
        join
        repeat (FRAME + 8) @(negedge clock);
        check("char after resume", u_sph_far_model.got.pop_front(), 8'h77);
        fork
            u_sph_far_model.send_byte(8'h3c);
            begin
                n = 0;
                while (rx_valid !== 1'b1 && n < 20 * FRAME) begin
                    @(negedge clock);
                    n++;
                end
                check("received", rx_data, 8'h3c);
            end
        join
        // ======================================
        // Data-set-ready lost mid-frame
        fork
            send_char(8'hc3, 3000, ok);
            begin
                @(posedge request_to_send_out);
                repeat (3 * DIV) @(negedge clock);
                data_set_ready_in = 1'b0;
            end
        join
        repeat (8) @(negedge clock);
        check("abort", {5'h00, alarm_active, transmit_line, request_to_send_out}, 8'h06);
        check("alarm code", alarm_code, ALARM_DSR_LOST);
        data_set_ready_in = 1'b1;
        send_char(8'h11, 2 * FRAME, ok);
        check("refused while alarmed", {7'h00, ok}, 8'h00);
        alarm_clear = 1'b1;
        @(negedge clock);
        alarm_clear = 1'b0;
        repeat (2) @(negedge clock);
        check("alarm cleared", {7'h00, alarm_active}, 8'h00);
        port_enable = 1'b0;
        repeat (4) @(negedge clock);
        check("not ready", {7'h00, terminal_ready_out}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
